// file: bench/iefl_evt_src.sv
`timescale 1ns/100ps

// Event sources: one kick bit per event, in event status order.
module iefl_evt_src
  import iefl_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [5:0] i_kick,
  output logic            o_tov,
  output logic            o_ext,
  output logic [3:0]      o_pins,
  output logic            o_osc,
  output logic            o_cmp,
  output logic            o_nvd
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {o_tov, o_ext, o_osc, o_cmp, o_nvd} <= 5'h00;
      o_pins <= 4'h0;
    end else begin
      o_tov <= i_kick[E_TO];
      o_ext <= i_kick[E_EX];
      o_pins <= i_kick[E_PC] ? o_pins + 4'h1 : o_pins;
      o_osc <= i_kick[E_OSC];
      o_cmp <= i_kick[E_CMP];
      o_nvd <= i_kick[E_NV];
    end
  end
endmodule

// file: bench/interrupt_enable_flag_logic_bench.sv
`timescale 1ns/100ps

module interrupt_enable_flag_logic_bench
  import iefl_pkg::*;
;
  logic                  i_clk;
  logic                  i_rst;
  iefl_apb_req_t         req;
  iefl_apb_rsp_t         rsp;
  logic [5:0]            kick;
  logic                  tov, ext, osc, cmp, nvd, irq, evt, err;
  logic [3:0]            pins;
  logic [31:0]           rd;
  int                    errors;
  int                    cmp_count;

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  iefl_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(req), .o_apb(rsp),
    .i_timer_overflow(tov), .i_ext_interrupt_pin(ext), .i_upper_port_pins(pins),
    .i_osc_fail(osc), .i_comparator_change(cmp), .i_nv_write_done(nvd),
    .o_irq_req(irq), .o_evt_irq(evt));

  iefl_evt_src src (.i_clk(i_clk), .i_rst(i_rst), .i_kick(kick), .o_tov(tov),
    .o_ext(ext), .o_pins(pins), .o_osc(osc), .o_cmp(cmp), .o_nvd(nvd));

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge i_clk);
    req.penable <= 1'b1;
    @(posedge i_clk);
    while (rsp.pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        tally_and_finish();
      end
      @(posedge i_clk);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h000000, d});
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(rd, exp);
  endtask

  task automatic fire(input int k);
    @(posedge i_clk);
    kick <= 6'h01 << k;
    @(posedge i_clk);
    kick <= 6'h00;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic lvl(input logic e, input logic sel);
    repeat (3) @(negedge i_clk);
    chk({31'h0, sel ? evt : irq}, {31'h0, e});
  endtask

  initial begin
    req = '0;
    kick = 6'h00;
    i_rst = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(IDX_INTCTL_B0, 32'h0);
    rdc(IDX_PFLAGS2, 32'h0);
    wr(IDX_INTCTL_B2, 8'hf8);
    rdc(IDX_INTCTL_B0, 32'hf8);
    rdc(IDX_INTCTL_B1, 32'hf8);
    rdc(IDX_INTCTL_B3, 32'hf8);
    wr(IDX_INTCTL_B0, 8'h00);
    fire(E_TO);
    fire(E_EX);
    fire(E_PC);
    rdc(IDX_INTCTL_B0, 32'h07);
    lvl(1'b0, 1'b0);
    wr(IDX_INTCTL_B0, 8'h00);
    rdc(IDX_INTCTL_B0, 32'h01);
    rdc(IDX_PORT_B, 32'h1);
    wr(IDX_INTCTL_B0, 8'h00);
    rdc(IDX_INTCTL_B0, 32'h0);
    wr(IDX_INTCTL_B0, 8'h20);
    fire(E_TO);
    lvl(1'b0, 1'b0);
    wr(IDX_INTCTL_B0, 8'ha4);
    lvl(1'b1, 1'b0);
    wr(IDX_INTCTL_B0, 8'h84);
    lvl(1'b0, 1'b0);
    wr(IDX_INTCTL_B0, 8'h90);
    fire(E_EX);
    lvl(1'b1, 1'b0);
    wr(IDX_INTCTL_B0, 8'h82);
    lvl(1'b0, 1'b0);
    wr(IDX_INTCTL_B0, 8'h88);
    fire(E_PC);
    lvl(1'b1, 1'b0);
    rdc(IDX_PORT_B, 32'h2);
    wr(IDX_INTCTL_B0, 8'h00);
    lvl(1'b0, 1'b0);
    fire(E_OSC);
    fire(E_CMP);
    fire(E_NV);
    rdc(IDX_PFLAGS2, 32'hd0);
    wr(IDX_PFLAGS2, 8'h2f);
    rdc(IDX_PFLAGS2, 32'h0);
    wr(IDX_PENABLE2, 8'h40);
    fire(E_CMP);
    wr(IDX_INTCTL_B0, 8'h80);
    lvl(1'b0, 1'b0);
    wr(IDX_INTCTL_B0, 8'hc0);
    lvl(1'b1, 1'b0);
    wr(IDX_PENABLE2, 8'h00);
    lvl(1'b0, 1'b0);
    rdc(IDX_EVT_STAT, 32'h3f);
    lvl(1'b0, 1'b1);
    wr(IDX_EVT_EN, 8'h01);
    lvl(1'b1, 1'b1);
    wr(IDX_EVT_CLR, 8'h01);
    lvl(1'b0, 1'b1);
    rdc(IDX_EVT_STAT, 32'h3e);
    rdc(IDX_EVT_CLR, 32'h0);
    wr(IDX_EVT_CLR, 8'h3f);
    rdc(IDX_EVT_STAT, 32'h0);
    kick <= 6'h21;
    wr(IDX_PFLAGS2, 8'h00);
    wr(IDX_INTCTL_B0, 8'h00);
    kick <= 6'h00;
    repeat (3) @(posedge i_clk);
    rdc(IDX_PFLAGS2, 32'h10);
    rdc(IDX_INTCTL_B0, 32'h04);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(IDX_INTCTL_B0, 32'h0);
    rdc(IDX_PFLAGS2, 32'h0);
    rdc(IDX_EVT_STAT, 32'h0);
    lvl(1'b0, 1'b0);
    apb(1'b0, 10'h030, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule

// file: logic/iefl_core.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps

module iefl_core
  import iefl_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire iefl_apb_req_t i_apb,
  output iefl_apb_rsp_t      o_apb,
  input  wire logic          i_timer_overflow,
  input  wire logic          i_ext_interrupt_pin,
  input  wire logic [3:0]    i_upper_port_pins,
  input  wire logic          i_osc_fail,
  input  wire logic          i_comparator_change,
  input  wire logic          i_nv_write_done,
  output logic               o_irq_req,
  output logic               o_evt_irq
);

  function automatic logic hit(input logic [AW-1:0] a, input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic [RW-1:0]   intctl_r;
  logic [RW-1:0]   pf2_r;
  logic [RW-1:0]   pe2_r;
  logic [NEVT-1:0] evt_stat_r;
  logic [NEVT-1:0] evt_en_r;
  logic [3:0]      pins_s1_r;
  logic [3:0]      pins_s2_r;
  logic [3:0]      last_read_r;
  logic            seeded_r;
  logic            ext_s1_r;
  logic            ext_s2_r;
  logic            ext_s3_r;
  iefl_apb_rsp_t   rsp_r;
  logic            irq_req_r;
  logic            evt_irq_r;

  logic            acc;
  logic            wr_fire;
  logic            rd_fire;
  logic            sel_intctl;
  logic            sel_pf2;
  logic            sel_port_b;
  logic            sel_pe2;
  logic            sel_stat;
  logic            sel_clr;
  logic            sel_en;
  logic            mapped;
  logic            mismatch;
  logic            ext_edge;
  logic [RW-1:0]   wdat;
  logic [NEVT-1:0] evt;
  logic [RW-1:0]   intctl_nxt;
  logic [RW-1:0]   pf2_nxt;
  logic [DW-1:0]   rdata;

  // Bus decode; the answer comes one cycle into the access phase.
  assign acc        = i_apb.psel & i_apb.penable & ~rsp_r.pready;
  assign wr_fire    = i_apb.psel & i_apb.penable & rsp_r.pready & i_apb.pwrite;
  assign rd_fire    = i_apb.psel & i_apb.penable & rsp_r.pready & ~i_apb.pwrite;
  assign sel_intctl = hit(i_apb.paddr, IDX_INTCTL_B0) | hit(i_apb.paddr, IDX_INTCTL_B1)
                    | hit(i_apb.paddr, IDX_INTCTL_B2) | hit(i_apb.paddr, IDX_INTCTL_B3);
  assign sel_pf2    = hit(i_apb.paddr, IDX_PFLAGS2);
  assign sel_port_b = hit(i_apb.paddr, IDX_PORT_B);
  assign sel_pe2    = hit(i_apb.paddr, IDX_PENABLE2);
  assign sel_stat   = hit(i_apb.paddr, IDX_EVT_STAT);
  assign sel_clr    = hit(i_apb.paddr, IDX_EVT_CLR);
  assign sel_en     = hit(i_apb.paddr, IDX_EVT_EN);
  assign mapped     = sel_intctl | sel_pf2 | sel_port_b | sel_pe2 | sel_stat | sel_clr | sel_en;
  assign wdat       = i_apb.pwdata[RW-1:0];

  // Event detection on synchronised pins.
  assign mismatch = seeded_r & (pins_s2_r != last_read_r);
  assign ext_edge = ext_s2_r & ~ext_s3_r;

  always_comb begin
    evt        = '0;
    evt[E_TO]  = i_timer_overflow;
    evt[E_EX]  = ext_edge;
    evt[E_PC]  = mismatch;
    evt[E_OSC] = i_osc_fail;
    evt[E_CMP] = i_comparator_change;
    evt[E_NV]  = i_nv_write_done;
  end

  // Flag update: a written value first, then hardware sets on top.
  always_comb begin
    intctl_nxt = intctl_r;
    if (wr_fire && sel_intctl) begin
      intctl_nxt = wdat;
    end
    intctl_nxt[B_TOF] = intctl_nxt[B_TOF] | evt[E_TO];
    intctl_nxt[B_EXF] = intctl_nxt[B_EXF] | evt[E_EX];
    intctl_nxt[B_PCF] = intctl_nxt[B_PCF] | evt[E_PC];
  end

  always_comb begin
    pf2_nxt = pf2_r;
    if (wr_fire && sel_pf2) begin
      pf2_nxt = wdat & PF2_MASK;
    end
    pf2_nxt[B_OSF] = pf2_nxt[B_OSF] | evt[E_OSC];
    pf2_nxt[B_CMF] = pf2_nxt[B_CMF] | evt[E_CMP];
    pf2_nxt[B_NVF] = pf2_nxt[B_NVF] | evt[E_NV];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      intctl_r <= INTCTL_RST;
      pf2_r    <= PF2_RST;
    end else begin
      intctl_r <= intctl_nxt;
      pf2_r    <= pf2_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pe2_r <= PE2_RST;
    end else if (wr_fire && sel_pe2) begin
      pe2_r <= wdat & PF2_MASK;
    end
  end

  // Pin synchronisers.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pins_s1_r <= PINS_RST;
      pins_s2_r <= PINS_RST;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
    end else begin
      pins_s1_r <= i_upper_port_pins;
      pins_s2_r <= pins_s1_r;
      ext_s1_r  <= i_ext_interrupt_pin;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
    end
  end

  // Last read port value; seeded once after reset, then on each port read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_read_r <= PINS_RST;
      seeded_r    <= 1'b0;
    end else if (!seeded_r || (rd_fire && sel_port_b)) begin
      last_read_r <= pins_s2_r;
      seeded_r    <= 1'b1;
    end
  end

  // Event status, write-one-to-clear with set winning, and its enable.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_stat_r <= EVT_RST;
    end else if (wr_fire && sel_clr) begin
      evt_stat_r <= (evt_stat_r & ~wdat[NEVT-1:0]) | evt;
    end else begin
      evt_stat_r <= evt_stat_r | evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_en_r <= EVT_RST;
    end else if (wr_fire && sel_en) begin
      evt_en_r <= wdat[NEVT-1:0];
    end
  end

  // Read mux.
  always_comb begin
    rdata = '0;
    unique case (1'b1)
      sel_intctl: rdata[RW-1:0] = intctl_r;
      sel_pf2:    rdata[RW-1:0] = pf2_r & PF2_MASK;
      sel_port_b: rdata[3:0]    = pins_s2_r;
      sel_pe2:    rdata[RW-1:0] = pe2_r;
      sel_stat:   rdata[NEVT-1:0] = evt_stat_r;
      default:    rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready  <= acc;
      rsp_r.pslverr <= acc & ~mapped;
      rsp_r.prdata  <= (acc && !i_apb.pwrite) ? rdata : '0;
    end
  end

  // Combined request to the core.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_req_r <= 1'b0;
    end else begin
      irq_req_r <= intctl_r[B_GLOBAL_EN] & (
                   (intctl_r[B_TOIE] & intctl_r[B_TOF]) |
                   (intctl_r[B_EXIE] & intctl_r[B_EXF]) |
                   (intctl_r[B_PCIE] & intctl_r[B_PCF]) |
                   (intctl_r[B_PERIPH_EN] & (|(pf2_r & pe2_r & PF2_MASK))));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_irq_r <= 1'b0;
    end else begin
      evt_irq_r <= |(evt_stat_r & evt_en_r);
    end
  end

  assign o_apb     = rsp_r;
  assign o_irq_req = irq_req_r;
  assign o_evt_irq = evt_irq_r;

  a_global_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !intctl_r[B_GLOBAL_EN] |=> !o_irq_req)
    else $error("request raised with global enable low");

  a_periph_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    (!intctl_r[B_PERIPH_EN] && !(intctl_r[B_TOIE] && intctl_r[B_TOF])
      && !(intctl_r[B_EXIE] && intctl_r[B_EXF]) && !(intctl_r[B_PCIE] && intctl_r[B_PCF]))
      |=> !o_irq_req)
    else $error("peripheral request passed with peripheral enable low");

  a_timer_req: assert property (@(posedge i_clk) disable iff (i_rst)
    (intctl_r[B_GLOBAL_EN] && intctl_r[B_TOIE] && intctl_r[B_TOF]) |=> o_irq_req)
    else $error("timer request missing");

  a_ext_req: assert property (@(posedge i_clk) disable iff (i_rst)
    (intctl_r[B_GLOBAL_EN] && intctl_r[B_EXIE] && intctl_r[B_EXF]) |=> o_irq_req)
    else $error("external request missing");

  a_port_req: assert property (@(posedge i_clk) disable iff (i_rst)
    (intctl_r[B_GLOBAL_EN] && intctl_r[B_PCIE] && intctl_r[B_PCF]) |=> o_irq_req)
    else $error("port change request missing");

  a_timer_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    i_timer_overflow |=> intctl_r[B_TOF])
    else $error("timer flag not set");

  a_ext_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(ext_s2_r) |=> intctl_r[B_EXF])
    else $error("external flag not set after pin edge");

  a_port_mismatch: assert property (@(posedge i_clk) disable iff (i_rst)
    mismatch |=> intctl_r[B_PCF])
    else $error("port flag not held during mismatch");

  a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    (intctl_r[B_TOF] && !(wr_fire && sel_intctl)) |=> intctl_r[B_TOF])
    else $error("timer flag dropped without software write");

  a_osc_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    i_osc_fail |=> pf2_r[B_OSF])
    else $error("oscillator fail flag not set");

  a_cmp_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    i_comparator_change |=> pf2_r[B_CMF])
    else $error("comparator flag not set");

  a_nv_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    i_nv_write_done |=> pf2_r[B_NVF])
    else $error("write done flag not set");

  a_pf2_unused: assert property (@(posedge i_clk) disable iff (i_rst)
    (pf2_r & ~PF2_MASK) == '0)
    else $error("unimplemented flag bit set");

  a_mirror_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_fire && hit(i_apb.paddr, IDX_INTCTL_B2))
      |=> intctl_r[B_GLOBAL_EN] == $past(wdat[B_GLOBAL_EN]))
    else $error("mirror write did not reach control register");

  a_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_fire && sel_pf2 && i_nv_write_done) |=> pf2_r[B_NVF])
    else $error("event lost against software clear");

  a_apb_answer: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_apb.psel && i_apb.penable && !o_apb.pready) |=> o_apb.pready)
    else $error("access not answered in one cycle");

  a_periph_req: assert property (@(posedge i_clk) disable iff (i_rst)
    (intctl_r[B_GLOBAL_EN] && intctl_r[B_PERIPH_EN] && (|(pf2_r & pe2_r & PF2_MASK)))
      |=> o_irq_req)
    else $error("peripheral request missing");

  a_evt_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
    (|(evt_stat_r & evt_en_r)) |=> o_evt_irq)
    else $error("event interrupt missing");

  a_evt_irq_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    (!(|(evt_stat_r & evt_en_r))) |=> !o_evt_irq)
    else $error("event interrupt raised with nothing enabled");

  a_port_read_ends: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_fire && sel_port_b) |=> (last_read_r == $past(pins_s2_r)))
    else $error("port read did not end the mismatch");

  a_apb_refuse: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_apb.psel && i_apb.penable && !o_apb.pready && !mapped) |=> o_apb.pslverr)
    else $error("unmapped access not refused");

  a_write_rdata: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_apb.psel && i_apb.penable && !o_apb.pready && i_apb.pwrite) |=> (o_apb.prdata == '0))
    else $error("read data not zero on a write");

  c_timer_irq: cover property (@(posedge i_clk) disable iff (i_rst)
    i_timer_overflow ##1 1'b1 ##1 o_irq_req);

  c_periph_irq: cover property (@(posedge i_clk) disable iff (i_rst)
    pf2_r[B_CMF] && o_irq_req);

  c_port_read: cover property (@(posedge i_clk) disable iff (i_rst)
    mismatch ##1 (rd_fire && sel_port_b));

  c_evt_irq: cover property (@(posedge i_clk) disable iff (i_rst)
    o_evt_irq ##[1:20] (wr_fire && sel_clr));

  c_set_wins: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && sel_pf2 && i_nv_write_done);

endmodule

// file: logic/iefl_pkg.sv
package iefl_pkg;

  localparam int AW = 12;
  localparam int DW = 32;
  localparam int RW = 8;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_INTCTL_B0 = 10'h00b;
  localparam logic [9:0] IDX_INTCTL_B1 = 10'h08b;
  localparam logic [9:0] IDX_INTCTL_B2 = 10'h10b;
  localparam logic [9:0] IDX_INTCTL_B3 = 10'h18b;
  localparam logic [9:0] IDX_PFLAGS2   = 10'h00d;
  localparam logic [9:0] IDX_PORT_B    = 10'h006;
  localparam logic [9:0] IDX_PENABLE2  = 10'h020;
  localparam logic [9:0] IDX_EVT_STAT  = 10'h021;
  localparam logic [9:0] IDX_EVT_CLR   = 10'h022;
  localparam logic [9:0] IDX_EVT_EN    = 10'h023;

  // Interrupt control bit positions.
  localparam int B_GLOBAL_EN = 7;
  localparam int B_PERIPH_EN = 6;
  localparam int B_TOIE      = 5;
  localparam int B_EXIE      = 4;
  localparam int B_PCIE      = 3;
  localparam int B_TOF       = 2;
  localparam int B_EXF       = 1;
  localparam int B_PCF       = 0;

  // Peripheral flag register 2 bit positions and implemented mask.
  localparam int B_OSF = 7;
  localparam int B_CMF = 6;
  localparam int B_NVF = 4;
  localparam logic [RW-1:0] PF2_MASK = 8'hd0;

  // Event status bit positions.
  localparam int E_TO  = 0;
  localparam int E_EX  = 1;
  localparam int E_PC  = 2;
  localparam int E_OSC = 3;
  localparam int E_CMP = 4;
  localparam int E_NV  = 5;
  localparam int NEVT  = 6;

  localparam logic [RW-1:0]   INTCTL_RST = 8'h00;
  localparam logic [RW-1:0]   PF2_RST    = 8'h00;
  localparam logic [RW-1:0]   PE2_RST    = 8'h00;
  localparam logic [NEVT-1:0] EVT_RST    = 6'h00;
  localparam logic [3:0]      PINS_RST   = 4'h0;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } iefl_apb_req_t;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [DW-1:0] prdata;
  } iefl_apb_rsp_t;

endpackage
